// >>> core/cbt_pkg.sv
// Constants, types and register layout for the CAN bit timing block
`default_nettype none
//**********************************************************************
// Summary of operation
//**********************************************************************
package cbt_pkg;

	//**********************************************************************
	// Register map
	//**********************************************************************
	localparam logic [7:0]  TIMING_OFS    = 8'h00;
	localparam logic [7:0]  DIR_OFS       = 8'h04;
	localparam logic [7:0]  STATUS_OFS    = 8'h08;
	localparam logic [15:0] TIMING_RESET  = 16'h0000;
	localparam logic [15:0] DIR_RESET     = 16'h0100;
	localparam logic [15:0] DIR_FIXED_MSK = 16'h0100;

	//**********************************************************************
	// Timing register fields and the direction spare bit
	//**********************************************************************
	localparam int SJW_LSB   = 14;
	localparam int SJW_W     = 2;
	localparam int PRESC_LSB = 8;
	localparam int PRESC_W   = 6;
	localparam int MODE_BIT  = 7;
	localparam int SEG2_LSB  = 4;
	localparam int SEG2_W    = 3;
	localparam int SEG1_LSB  = 0;
	localparam int SEG1_W    = 4;
	localparam int DIR_SPARE = 8;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CBT_SYNC = 2'h0,
		CBT_SEG1 = 2'h1,
		CBT_SEG2 = 2'h2
	} cbt_phase_e;

	typedef logic [4:0] cbt_quanta_t;

endpackage : cbt_pkg

`default_nettype wire

// >>> core/cbt_links_if.sv
// Interfaces between the timing core, the quantum divider and the sampler
`timescale 1ns/10ps
`default_nettype none

interface cbt_tq_if;
	logic [5:0] prescale;
	logic       restart;
	logic       tick;
	modport core (output prescale, output restart, input tick);
	modport div  (input prescale, input restart, output tick);
endinterface : cbt_tq_if

interface cbt_smp_if;
	logic rx;
	logic triple;
	logic strobe_pre;
	logic strobe_mid;
	logic strobe_post;
	logic bit_valid;
	logic bit_val;
	modport core (output rx, output triple, output strobe_pre, output strobe_mid,
		output strobe_post, input bit_valid, input bit_val);
	modport smp  (input rx, input triple, input strobe_pre, input strobe_mid,
		input strobe_post, output bit_valid, output bit_val);
endinterface : cbt_smp_if

`default_nettype wire

// >>> core/cbt_quantum.sv
// Time quantum divider of the system clock
`timescale 1ns/10ps
`default_nettype none

module cbt_quantum (
	input  wire logic aclk,
	input  wire logic aresetn,
	cbt_tq_if.div     tq
);
	logic [6:0] cnt_r;
	logic [6:0] last;

	// Code k lasts 2*(k+1) clocks
	assign last = {tq.prescale, 1'b1};

	always_ff @(posedge aclk) begin
		if (!aresetn || tq.restart) begin
			cnt_r <= 7'h00;
		end else if (cnt_r >= last) begin
			cnt_r <= 7'h00;
		end else begin
			cnt_r <= cnt_r + 7'h01;
		end
	end

	assign tq.tick = (cnt_r >= last) && !tq.restart;

endmodule : cbt_quantum

`default_nettype wire

// >>> core/cbt_sampler.sv
// Single or three point bit sampler
`timescale 1ns/10ps
`default_nettype none

module cbt_sampler (
	input  wire logic aclk,
	input  wire logic aresetn,
	cbt_smp_if.smp    smp
);
	logic pre_r;
	logic mid_r;
	logic valid_r;
	logic val_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_r <= 1'b1;
			mid_r <= 1'b1;
		end else begin
			if (smp.strobe_pre) begin
				pre_r <= smp.rx;
			end
			if (smp.strobe_mid) begin
				mid_r <= smp.rx;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valid_r <= 1'b0;
			val_r   <= 1'b1;
		end else if (!smp.triple && smp.strobe_mid) begin
			valid_r <= 1'b1;
			val_r   <= smp.rx;
		end else if (smp.triple && smp.strobe_post) begin
			valid_r <= 1'b1;
			// Majority of three rejects one disturbed quantum
			val_r   <= (pre_r & mid_r) | (pre_r & smp.rx) | (mid_r & smp.rx);
		end else begin
			valid_r <= 1'b0;
		end
	end

	assign smp.bit_valid = valid_r;
	assign smp.bit_val   = val_r;

endmodule : cbt_sampler

`default_nettype wire

// >>> core/cbt_top.sv
// CAN bit timing and mailbox direction configuration with AXI4-Lite access
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module cbt_top #(
	parameter int ADDR_W   = 8,
	parameter int MB_COUNT = 15
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              can_rx,
	output logic                   rx_bit_valid,
	output logic                   rx_bit,
	output logic                   bit_start,
	output logic [MB_COUNT-1:0]    mailbox_receive
);

	//**********************************************************************
	// Elaboration checks
	//**********************************************************************
	// Bit mapping of the direction register is fixed for fifteen boxes
	if (MB_COUNT != 15) begin : g_bad_count
		$error("cbt_top supports exactly fifteen mailboxes");
	end
	if (ADDR_W < 4) begin : g_bad_addr
		$error("cbt_top needs at least four address bits");
	end

	//**********************************************************************
	// Helpers
	//**********************************************************************
	function automatic cbt_pkg::cbt_quanta_t min_q(input cbt_pkg::cbt_quanta_t a,
		input cbt_pkg::cbt_quanta_t b);
		min_q = (a < b) ? a : b;
	endfunction : min_q

	function automatic logic [15:0] merge16(input logic [15:0] old_v,
		input logic [31:0] data, input logic [3:0] strb);
		merge16 = {strb[1] ? data[15:8] : old_v[15:8], strb[0] ? data[7:0] : old_v[7:0]};
	endfunction : merge16

	//**********************************************************************
	// Register bus slave
	//**********************************************************************
	logic [15:0]       timing_r;
	logic [15:0]       dir_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic              aw_held_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              w_held_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              arready_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;
	logic              wr_go;
	logic              wr_timing;
	logic              wr_dir;
	logic [31:0]       status_word;

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready  = !w_held_r && !bvalid_r;
	assign wr_go         = aw_held_r && w_held_r && !bvalid_r;
	assign wr_timing     = wr_go && (awaddr_r == ADDR_W'(cbt_pkg::TIMING_OFS));
	assign wr_dir        = wr_go && (awaddr_r == ADDR_W'(cbt_pkg::DIR_OFS));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r  <= 32'h00000000;
			wstrb_r  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= cbt_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			if (wr_timing || wr_dir) begin
				bresp_r <= cbt_pkg::RESP_OKAY;
			end else begin
				bresp_r <= cbt_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;

	// Prohibited segment codes are stored as written; software keeps them out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timing_r <= cbt_pkg::TIMING_RESET;
		end else if (wr_timing) begin
			timing_r <= merge16(timing_r, wdata_r, wstrb_r);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_r <= cbt_pkg::DIR_RESET;
		end else if (wr_dir) begin
			// Spare bit stays one whatever is written
			dir_r <= merge16(dir_r, wdata_r, wstrb_r) | cbt_pkg::DIR_FIXED_MSK;
		end
	end

	assign s_axi_arready = arready_r && !rvalid_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
		end else begin
			arready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= cbt_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r  <= cbt_pkg::RESP_OKAY;
			if (s_axi_araddr == ADDR_W'(cbt_pkg::TIMING_OFS)) begin
				rdata_r <= {16'h0000, timing_r};
			end else if (s_axi_araddr == ADDR_W'(cbt_pkg::DIR_OFS)) begin
				rdata_r <= {16'h0000, dir_r};
			end else if (s_axi_araddr == ADDR_W'(cbt_pkg::STATUS_OFS)) begin
				rdata_r <= status_word;
			end else begin
				rdata_r <= 32'h00000000;
				rresp_r <= cbt_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;

	//**********************************************************************
	// Mailbox direction
	//**********************************************************************
	// Output index n-1 is mailbox n; one means receive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mailbox_receive <= '0;
		end else begin
			mailbox_receive <= {dir_r[7:0], dir_r[15:9]};
		end
	end

	//**********************************************************************
	// Receive pin synchroniser
	//**********************************************************************
	logic rx_s1_r;
	logic rx_s2_r;
	logic rx_s3_r;
	logic rx_lvl_r;
	logic edge_pend_r;
	logic fall;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_s3_r <= 1'b1;
		end else begin
			rx_s1_r <= can_rx;
			rx_s2_r <= rx_s1_r;
			rx_s3_r <= rx_s2_r;
		end
	end

	assign fall = rx_lvl_r && (rx_s2_r == rx_s3_r) && !rx_s2_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_lvl_r <= 1'b1;
		end else if (rx_s2_r == rx_s3_r) begin
			rx_lvl_r <= rx_s2_r;
		end
	end

	//**********************************************************************
	// Bit segment sequencer
	//**********************************************************************
	cbt_tq_if  tq_l ();
	cbt_smp_if smp_l ();

	cbt_pkg::cbt_phase_e  phase_r;
	cbt_pkg::cbt_quanta_t cnt_r;
	cbt_pkg::cbt_quanta_t lim1_r;
	cbt_pkg::cbt_quanta_t lim2_r;
	cbt_pkg::cbt_quanta_t t1;
	cbt_pkg::cbt_quanta_t t2;
	cbt_pkg::cbt_quanta_t sync_jump_width;
	cbt_pkg::cbt_quanta_t lim1_eff;
	cbt_pkg::cbt_quanta_t lim2_eff;
	logic                 resync_done_r;
	logic                 act;
	logic                 early_sync;

	assign t1  = cbt_pkg::cbt_quanta_t'(timing_r[cbt_pkg::SEG1_LSB +: cbt_pkg::SEG1_W]) + 5'h01;
	assign t2  = cbt_pkg::cbt_quanta_t'(timing_r[cbt_pkg::SEG2_LSB +: cbt_pkg::SEG2_W]) + 5'h01;
	assign sync_jump_width = cbt_pkg::cbt_quanta_t'(timing_r[cbt_pkg::SJW_LSB +: cbt_pkg::SJW_W]) + 5'h01;

	assign act        = tq_l.tick && edge_pend_r && !resync_done_r;
	// Late edge stretches segment one by the phase error, capped at the jump width
	assign lim1_eff   = (act && phase_r == cbt_pkg::CBT_SEG1) ?
		lim1_r + min_q(cnt_r + 5'h01, sync_jump_width) : lim1_r;
	// Early edge inside reach of the jump width becomes the next sync quantum
	assign early_sync = act && phase_r == cbt_pkg::CBT_SEG2 && (lim2_r - cnt_r) <= sync_jump_width;
	assign lim2_eff   = (act && phase_r == cbt_pkg::CBT_SEG2) ? lim2_r - sync_jump_width : lim2_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			edge_pend_r <= 1'b0;
		end else if (fall) begin
			edge_pend_r <= 1'b1;
		end else if (tq_l.tick) begin
			edge_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_r       <= cbt_pkg::CBT_SYNC;
			cnt_r         <= 5'h00;
			lim1_r        <= 5'h04;
			lim2_r        <= 5'h02;
			resync_done_r <= 1'b0;
		end else if (tq_l.tick) begin
			case (phase_r)
				cbt_pkg::CBT_SYNC: begin
					phase_r       <= cbt_pkg::CBT_SEG1;
					cnt_r         <= 5'h00;
					lim1_r        <= t1;
					resync_done_r <= 1'b0;
				end
				cbt_pkg::CBT_SEG1: begin
					lim1_r <= lim1_eff;
					if (act) begin
						resync_done_r <= 1'b1;
					end
					if (cnt_r >= lim1_eff - 5'h01) begin
						phase_r <= cbt_pkg::CBT_SEG2;
						cnt_r   <= 5'h00;
						lim2_r  <= t2;
					end else begin
						cnt_r <= cnt_r + 5'h01;
					end
				end
				cbt_pkg::CBT_SEG2: begin
					if (early_sync) begin
						phase_r       <= cbt_pkg::CBT_SEG1;
						cnt_r         <= 5'h00;
						lim1_r        <= t1;
						resync_done_r <= 1'b0;
					end else begin
						lim2_r <= lim2_eff;
						if (act) begin
							resync_done_r <= 1'b1;
						end
						if (cnt_r >= lim2_eff - 5'h01) begin
							phase_r <= cbt_pkg::CBT_SYNC;
							cnt_r   <= 5'h00;
						end else begin
							cnt_r <= cnt_r + 5'h01;
						end
					end
				end
				default: begin
					phase_r <= cbt_pkg::CBT_SYNC;
					cnt_r   <= 5'h00;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bit_start <= 1'b0;
		end else begin
			bit_start <= tq_l.tick && (phase_r == cbt_pkg::CBT_SYNC || early_sync);
		end
	end

	//**********************************************************************
	// Quantum divider and sampler
	//**********************************************************************
	// A new prescaler restarts the quantum so no stretched quantum appears
	assign tq_l.prescale = timing_r[cbt_pkg::PRESC_LSB +: cbt_pkg::PRESC_W];
	assign tq_l.restart  = wr_timing;

	cbt_quantum u_quantum (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tq      (tq_l)
	);

	assign smp_l.rx          = rx_lvl_r;
	assign smp_l.triple      = timing_r[cbt_pkg::MODE_BIT];
	assign smp_l.strobe_mid  = tq_l.tick && phase_r == cbt_pkg::CBT_SEG1 &&
		cnt_r >= lim1_eff - 5'h01;
	assign smp_l.strobe_pre  = tq_l.tick && phase_r == cbt_pkg::CBT_SEG1 &&
		cnt_r == lim1_eff - 5'h02;
	assign smp_l.strobe_post = tq_l.tick && phase_r == cbt_pkg::CBT_SEG2 &&
		cnt_r == 5'h00 && !early_sync;

	cbt_sampler u_sampler (
		.aclk    (aclk),
		.aresetn (aresetn),
		.smp     (smp_l)
	);

	assign rx_bit_valid = smp_l.bit_valid;
	assign rx_bit       = smp_l.bit_val;

	assign status_word = {24'h000000, rx_lvl_r, resync_done_r, phase_r, cnt_r[3:0]};

endmodule : cbt_top

`default_nettype wire

// >>> tb/cbt_monitor.sv
// Checker of bus and output behaviour at the top ports
`timescale 1ns/10ps
`default_nettype none

module cbt_monitor #(
	parameter int ADDR_W   = 8,
	parameter int MB_COUNT = 15
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              rx_bit_valid,
	input wire logic              bit_start,
	input wire logic [MB_COUNT-1:0] mailbox_receive
);
	//********************
	// Checks
	//********************
	logic rd_dir_r;

	// Remembers whether the read in flight targets the direction register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_dir_r <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_dir_r <= (s_axi_araddr == ADDR_W'(cbt_pkg::DIR_OFS));
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_B_HOLD:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_B_AFTER_AW_W:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid) else $error("write response late");
	AST_W_BLOCK:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	AST_R_AFTER_AR:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_HOLD:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_AR_BLOCK:
		assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted early");
	AST_MBOX_MAP:
		assert property (s_axi_rvalid && rd_dir_r
			|-> mailbox_receive == {s_axi_rdata[7:0], s_axi_rdata[15:9]})
		else $error("mailbox direction outputs differ from register");
	AST_SPARE_ONE:
		assert property (s_axi_rvalid && rd_dir_r |-> s_axi_rdata[8] && !s_axi_rdata[16])
		else $error("spare direction bit not read as one");
	AST_SAMPLE_PULSE:
		assert property (rx_bit_valid |=> !rx_bit_valid) else $error("sample pulse too long");
	AST_BIT_PULSE:
		assert property (bit_start |=> !bit_start) else $error("bit start pulse too long");

endmodule : cbt_monitor

bind cbt_top cbt_monitor #(.ADDR_W(ADDR_W), .MB_COUNT(MB_COUNT)) i_cbt_monitor (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_bit_valid,
	.bit_start, .mailbox_receive
);

`default_nettype wire

// >>> tb/cbt_can_node.sv
// Model of another node driving the CAN bus
`timescale 1ns/10ps
`default_nettype none

module cbt_can_node (
	input  wire logic aclk,
	output logic      can_rx,
	output logic      cur_bit,
	output logic      checking
);
	//********************
	// Bus driver
	//********************
	// Idle bus rests recessive, the level its pull-up gives
	initial begin
		can_rx   = 1'b1;
		cur_bit  = 1'b1;
		checking = 1'b0;
	end

	// First 8 bits are a toggling preamble so the receiver can resync
	task automatic send(input logic [31:0] bits, input int clks);
		int i;
		for (i = 31; i >= 0; i--) begin
			can_rx   <= bits[i];
			cur_bit  <= bits[i];
			checking <= (i < 24);
			repeat (clks) @(posedge aclk);
		end
		can_rx   <= 1'b1;
		cur_bit  <= 1'b1;
		checking <= 1'b0;
	endtask : send

endmodule : cbt_can_node

`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the CAN bit timing block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	//********************
	// Signals
	//********************
	logic        aclk, aresetn, can_rx, rx_bit_valid, rx_bit, bit_start, cur_bit, checking;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic [14:0] mailbox_receive, mb;
	logic [15:0] cfg [4] = '{16'h0013, 16'hFFFF, 16'h45B8, 16'h8165};
	int          errors, n_compared, i, n, tq, n_rx;

	cbt_top i_cbt_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .can_rx, .rx_bit_valid, .rx_bit,
		.bit_start, .mailbox_receive);
	cbt_can_node i_cbt_can_node (.aclk, .can_rx, .cur_bit, .checking);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	//********************
	// Tasks
	//********************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic hang();
		errors++;
		$display("ERROR at %0t: got %h expected %h", $time, 32'h0, 32'h1);
		report_and_stop();
	endtask : hang

	task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] r);
		int k;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (k == 200) hang();
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] r);
		int k;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (k == 200) hang();
		rd = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_read

	task automatic wr_chk(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] er);
		logic [1:0] r;
		axi_write(a, wd, r);
		check({30'h0, r}, {30'h0, er});
	endtask : wr_chk

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] rd;
		logic [1:0]  r;
		axi_read(a, rd, r);
		check(rd, ed);
		check({30'h0, r}, {30'h0, er});
	endtask : rd_chk

	task automatic wait_bs();
		int k;
		for (k = 0; k < 5000; k++) begin
			@(posedge aclk);
			if (bit_start === 1'b1) break;
		end
		if (k == 5000) hang();
	endtask : wait_bs

	// Idle bus gives no resync, so bit length and sample offset are exact
	task automatic measure(input int per, input int off);
		int c;
		int v;
		v = -1;
		wait_bs();
		wait_bs();
		for (c = 1; c < 5000; c++) begin
			@(posedge aclk);
			if (rx_bit_valid === 1'b1 && v < 0) v = c;
			if (bit_start === 1'b1) break;
		end
		check(c, per);
		check(v, off);
	endtask : measure

	always @(posedge aclk) begin
		if (rx_bit_valid === 1'b1 && checking) begin
			n_rx++;
			check({31'h0, rx_bit}, {31'h0, cur_bit});
		end
	end

	//********************
	// Sequence
	//********************
	initial begin
		seed = 32'h3F7E6FBC;
		errors = 0;
		n_compared = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		n_rx = 0;
		rd_chk(cbt_pkg::TIMING_OFS, 32'h00000000, 2'h0);
		rd_chk(cbt_pkg::DIR_OFS, 32'h00000100, 2'h0);
		check({17'h0, mailbox_receive}, 32'h00000000);
		$display("test reset values done");
		// Only legal segment codes are ever written
		for (i = 0; i < 4; i++) begin
			wr_chk(cbt_pkg::TIMING_OFS, {16'(xs() >> 16), cfg[i]}, 2'h0);
			rd_chk(cbt_pkg::TIMING_OFS, {16'h0, cfg[i]}, 2'h0);
			tq = 2 * (cfg[i][13:8] + 1);
			measure(tq * (3 + cfg[i][6:4] + cfg[i][3:0]), tq * (cfg[i][3:0] + 1 + cfg[i][7]));
		end
		$display("test bit timing done");
		for (i = 0; i < 5; i++) begin
			d = (i == 0) ? 32'h0000FFFF : (i == 1) ? 32'h00000100 : (xs() | 32'h00000100);
			wr_chk(cbt_pkg::DIR_OFS, d, 2'h0);
			rd_chk(cbt_pkg::DIR_OFS, {16'h0, d[15:0]}, 2'h0);
			for (n = 1; n <= 15; n++) mb[n-1] = d[(n <= 7) ? 8 + n : n - 8];
			check({17'h0, mailbox_receive}, {17'h0, mb});
		end
		// Low byte strobe only: upper byte keeps its value
		s_axi_wstrb <= 4'h1;
		wr_chk(cbt_pkg::DIR_OFS, 32'h000000A5, 2'h0);
		s_axi_wstrb <= 4'hF;
		d = {16'h0000, d[15:8] | 8'h01, 8'hA5};
		rd_chk(cbt_pkg::DIR_OFS, d, 2'h0);
		wr_chk(8'h0C, xs(), 2'h2);
		rd_chk(8'h10, 32'h00000000, 2'h2);
		rd_chk(cbt_pkg::DIR_OFS, {16'h0, d[15:0]}, 2'h0);
		// Idle bus: filtered level reads recessive, upper bits zero
		axi_read(cbt_pkg::STATUS_OFS, d, rr);
		check({d[31:7], 7'h00}, 32'h00000080);
		check({30'h0, rr}, 32'h00000000);
		$display("test mailbox direction done");
		for (i = 0; i < 2; i++) begin
			wr_chk(cbt_pkg::TIMING_OFS, (i == 0) ? 32'h0000C065 : 32'h0000C0E5, 2'h0);
			@(posedge aclk);
			i_cbt_can_node.send({8'h55, 24'(xs() >> 8)}, 28);
			check(n_rx, 24 * (i + 1));
		end
		$display("test received bits done");
		report_and_stop();
	end

endmodule : tb_top

`default_nettype wire
